// *** core/usb_ctrl_pkg.sv ***
// shared constants and types for the usb control register block
package usb_ctrl_pkg;
	// ---------------------------------------------------------------
	// register byte addresses
	// ---------------------------------------------------------------
	localparam logic [31:0] CMD_STROBES_ADDR = 32'hFFF0603C;
	localparam logic [31:0] CTRL_STATUS_ADDR = 32'hFFF06040;
	localparam logic [31:0] SW_CONFIG_ADDR = 32'hFFF06044;
	localparam logic [31:0] EP_A_IDENTITY_ADDR = 32'hFFF06048;
	localparam logic [31:0] EP_A_CONTROL_ADDR = 32'hFFF0604C;
	localparam logic [31:0] CTRL_IN_WORD0_ADDR = 32'hFFF06028;
	localparam int CTRL_IN_WORDS = 4;
	// ---------------------------------------------------------------
	// field positions and masks
	// ---------------------------------------------------------------
	localparam int FETCH_BIT = 3;
	localparam int LAST_BIT = 2;
	localparam int STALL_BIT = 1;
	localparam int READY_BIT = 0;
	localparam int STROBE_COUNT = 4;
	localparam int HOST_CONFIG_LSB = 8;
	localparam int RXSIZE_W = 5;
	localparam logic [31:0] EP_A_IDENTITY_MASK = 32'h73FFFFFF;
	localparam logic [31:0] EP_A_CONTROL_MASK = 32'h0000007F;
	localparam logic [31:0] SW_CONFIG_MASK = 32'h000000FF;
	localparam logic [31:0] RESET_VALUE = 32'h00000000;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int STROBE_HOLD_CYCLES = 32;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic fetch;
		logic last_packet;
		logic stall;
		logic data_ready;
	} strobe_type;
	typedef struct packed {
		logic [7:0] host_config_value;
		logic [4:0] ctrl_rx_packet_size;
	} link_status_type;
endpackage : usb_ctrl_pkg

// *** core/strobe_timer.sv ***
// one self-clearing command strobe bit
module strobe_timer
	import usb_ctrl_pkg::*;
#(
	parameter int HOLD = STROBE_HOLD_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic set,
	output logic level
);
	logic [5:0] count;
	wire done = (count == 6'(HOLD - 1));
	// [R3] auto clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			level <= 1'b0;
			count <= 6'h00;
		end else if (set) begin
			level <= 1'b1;
			count <= 6'h00;
		end else if (level) begin
			level <= !done;
			count <= count + 6'h01;
		end
	end
	// [R3] helper: cycles the strobe has stood since its last set
	// counted here because a long repetition would be unrolled by the tools
	logic [6:0] high_run;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			high_run <= 7'h00;
		end else if (set || !level) begin
			high_run <= 7'h00;
		end else begin
			high_run <= high_run + 7'h01;
		end
	end
	// [R3] clears after hold
	hold_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
		high_run == 7'(HOLD) |-> !level)
		else $error("strobe not cleared after hold");
endmodule : strobe_timer

// *** core/addr_match.sv ***
// aligned word address decoder
module addr_match
	import usb_ctrl_pkg::*;
(
	input wire logic [31:0] addr,
	output logic [7:0] hit
);
	assign hit[0] = (addr[31:2] == CMD_STROBES_ADDR[31:2]);
	assign hit[1] = (addr[31:2] == CTRL_STATUS_ADDR[31:2]);
	assign hit[2] = (addr[31:2] == SW_CONFIG_ADDR[31:2]);
	assign hit[3] = (addr[31:2] == EP_A_IDENTITY_ADDR[31:2]);
	assign hit[4] = (addr[31:2] == EP_A_CONTROL_ADDR[31:2]);
	// in-data window of four words
	assign hit[5] = (addr[31:4] == CTRL_IN_WORD0_ADDR[31:4]) && (addr[3:2] >= 2'h2);
	assign hit[6] = (addr[31:2] == CTRL_IN_WORD0_ADDR[31:2] + 30'h2);
	assign hit[7] = (addr[31:2] == CTRL_IN_WORD0_ADDR[31:2] + 30'h3);
endmodule : addr_match

// *** core/usb_device_control_endpoint_regs.sv ***
// axi4-lite register block for the usb device control engine
// Overview of operation
// [R1] a written one at bit 3 fetches pending setup or bulk-out data
// [R2] written zeros on strobe bits do nothing
// [R3] each strobe clears itself 32 clocks after being set
// [R4] bit 2 marks current data-in packet as the last one
// [R5] bit 1 makes the engine stall the current class or vendor command
// [R6] bit 0 says the data-in packet is prepared and ready to send
// [R7] status bits 15:8 show the host-set configuration value
// [R8] status bits 4:0 show the received control packet size
// [R9] separate read/write 8-bit software configuration value
// [R10] endpoint A identity register with its field layout
// [R11] endpoint A control register, bits 6:0 used, bit 7 reserved
// [R12] four 32-bit in-data words loaded before data ready
// [R13] reserved bits read zero, status register ignores writes
//
// Local design decision: the AXI4-Lite register port.
module usb_device_control_endpoint_regs
	import usb_ctrl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] host_config_value,
	input wire logic [4:0] ctrl_rx_packet_size,
	output logic setup_bulkout_fetch,
	output logic cmd_last_packet,
	output logic cmd_stall,
	output logic cmd_data_ready,
	output logic [7:0] sw_config_value,
	output logic [31:0] endpoint_a_identity,
	output logic [31:0] endpoint_a_control,
	output logic [127:0] ctrl_in_data
);
	// ---------------------------------------------------------------
	// reset release
	// ---------------------------------------------------------------
	logic rst_meta;
	logic rst_sync_n;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// ---------------------------------------------------------------
	// write channel capture
	// ---------------------------------------------------------------
	logic aw_held;
	logic w_held;
	logic [31:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire [31:0] wr_addr = aw_take ? s_axi_awaddr : aw_addr;
	wire [31:0] wr_data = w_take ? s_axi_wdata : w_data;
	wire [3:0] wr_strb = w_take ? s_axi_wstrb : w_strb;
	wire wr_fire = (aw_held || aw_take) && (w_held || w_take) && !s_axi_bvalid;
	logic [7:0] wr_hit;
	logic [7:0] rd_hit;
	addr_match wr_dec (.addr(wr_addr), .hit(wr_hit));
	addr_match rd_dec (.addr(s_axi_araddr), .hit(rd_hit));
	wire wr_known = |wr_hit;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return ((old & ~m) | (data & m)) & mask;
	endfunction : merge

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= RESET_VALUE;
			w_data <= RESET_VALUE;
			w_strb <= 4'h0;
		end else begin
			aw_held <= (aw_held || aw_take) && !wr_fire;
			w_held <= (w_held || w_take) && !wr_fire;
			if (aw_take) aw_addr <= s_axi_awaddr;
			if (w_take) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_held && !aw_take && !s_axi_bvalid && !wr_fire;
			s_axi_wready <= !w_held && !w_take && !s_axi_bvalid && !wr_fire;
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// command strobes
	// ---------------------------------------------------------------
	// [R2] only ones trigger
	wire strobe_lane = wr_fire && wr_hit[0] && wr_strb[0];
	wire [3:0] strobe_set = strobe_lane ? wr_data[3:0] : 4'h0;
	strobe_type strobes;
	// [R1] [R4] [R5] [R6] per-bit timers
	strobe_timer #(.HOLD(STROBE_HOLD_CYCLES)) t_fetch (.clk(sys_clk), .rst_n(rst_sync_n),
		.set(strobe_set[FETCH_BIT]), .level(strobes.fetch));
	strobe_timer #(.HOLD(STROBE_HOLD_CYCLES)) t_last (.clk(sys_clk), .rst_n(rst_sync_n),
		.set(strobe_set[LAST_BIT]), .level(strobes.last_packet));
	strobe_timer #(.HOLD(STROBE_HOLD_CYCLES)) t_stall (.clk(sys_clk), .rst_n(rst_sync_n),
		.set(strobe_set[STALL_BIT]), .level(strobes.stall));
	strobe_timer #(.HOLD(STROBE_HOLD_CYCLES)) t_ready (.clk(sys_clk), .rst_n(rst_sync_n),
		.set(strobe_set[READY_BIT]), .level(strobes.data_ready));
	assign setup_bulkout_fetch = strobes.fetch;
	assign cmd_last_packet = strobes.last_packet;
	assign cmd_stall = strobes.stall;
	assign cmd_data_ready = strobes.data_ready;

	// ---------------------------------------------------------------
	// writable registers
	// ---------------------------------------------------------------
	logic [31:0] sw_config_reg;
	logic [31:0] ctrl_in_word [CTRL_IN_WORDS];
	assign sw_config_value = sw_config_reg[7:0];
	assign ctrl_in_data = {ctrl_in_word[3], ctrl_in_word[2], ctrl_in_word[1], ctrl_in_word[0]};
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			sw_config_reg <= RESET_VALUE;
			endpoint_a_identity <= RESET_VALUE;
			endpoint_a_control <= RESET_VALUE;
			for (int i = 0; i < CTRL_IN_WORDS; i++) ctrl_in_word[i] <= RESET_VALUE;
		end else if (wr_fire) begin
			// [R9] software configuration value
			if (wr_hit[2]) sw_config_reg <= merge(sw_config_reg, wr_data, wr_strb, SW_CONFIG_MASK);
			// [R10] identity fields
			if (wr_hit[3]) endpoint_a_identity <= merge(endpoint_a_identity, wr_data, wr_strb,
				EP_A_IDENTITY_MASK);
			// [R11] control fields
			if (wr_hit[4]) endpoint_a_control <= merge(endpoint_a_control, wr_data, wr_strb,
				EP_A_CONTROL_MASK);
			// [R12] in-data words
			for (int i = 0; i < CTRL_IN_WORDS; i++) begin
				if (wr_addr[31:2] == CTRL_IN_WORD0_ADDR[31:2] + 30'(i))
					ctrl_in_word[i] <= merge(ctrl_in_word[i], wr_data, wr_strb, 32'hFFFFFFFF);
			end
		end
	end

	// ---------------------------------------------------------------
	// read channel
	// ---------------------------------------------------------------
	link_status_type status;
	assign status = '{host_config_value: host_config_value,
		ctrl_rx_packet_size: ctrl_rx_packet_size};
	// [R7] [R8] status layout, [R13] reserved read zero
	wire [31:0] status_word = {16'h0000, status.host_config_value, 3'h0,
		status.ctrl_rx_packet_size};
	wire [31:0] strobe_word = {28'h0000000, strobes};
	// in-data words only: the neighbouring out-data and bus status words are not ours
	wire in_hit = |rd_hit[7:5];
	wire [1:0] in_index = 2'(s_axi_araddr[31:2] - CTRL_IN_WORD0_ADDR[31:2]);
	wire rd_known = |rd_hit[4:0] || in_hit;
	wire [31:0] rd_word = rd_hit[0] ? strobe_word :
		rd_hit[1] ? status_word :
		rd_hit[2] ? sw_config_reg :
		rd_hit[3] ? endpoint_a_identity :
		rd_hit[4] ? endpoint_a_control :
		in_hit ? ctrl_in_word[in_index] : RESET_VALUE;
	wire ar_take = s_axi_arvalid && s_axi_arready;
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= RESET_VALUE;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !ar_take;
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_sync_n);
	sequence fetch_written;
		wr_fire && wr_hit[0] && wr_strb[0] && wr_data[FETCH_BIT];
	endsequence
	fetch_rise_a: assert property (fetch_written |=> setup_bulkout_fetch) // [R1]
		else $error("fetch strobe not raised");
	zero_write_a: assert property ($rose(cmd_stall) |-> $past(strobe_set[STALL_BIT])) // [R2]
		else $error("stall strobe rose without a written one");
	last_rise_a: assert property (wr_fire && wr_hit[0] && wr_strb[0] && wr_data[LAST_BIT]
		|=> cmd_last_packet) // [R4]
		else $error("last packet strobe not raised");
	stall_rise_a: assert property (strobe_set[STALL_BIT] |=> cmd_stall [*8]) // [R5]
		else $error("stall strobe dropped early");
	ready_rise_a: assert property (strobe_set[READY_BIT] |=> cmd_data_ready) // [R6]
		else $error("data ready strobe not raised");
	host_config_value_read_a: assert property (ar_take && rd_hit[1]
		|=> s_axi_rdata[15:8] == $past(host_config_value)) // [R7]
		else $error("configured value misreported");
	size_read_a: assert property (ar_take && rd_hit[1]
		|=> s_axi_rdata[4:0] == $past(ctrl_rx_packet_size)) // [R8]
		else $error("packet size misreported");
	config_write_a: assert property (wr_fire && wr_hit[2] && wr_strb[0]
		|=> sw_config_value == $past(wr_data[7:0])) // [R9]
		else $error("config value not stored");
	ident_reserved_a: assert property (endpoint_a_identity[31] == 1'b0 &&
		endpoint_a_identity[27:26] == 2'b00) // [R10]
		else $error("identity reserved bit set");
	control_reserved_a: assert property (endpoint_a_control[31:7] == 25'h0) // [R11]
		else $error("control reserved bit set");
	in_word_a: assert property (wr_fire && wr_addr[31:2] == CTRL_IN_WORD0_ADDR[31:2] &&
		wr_strb == 4'hF |=> ctrl_in_data[31:0] == $past(wr_data)) // [R12]
		else $error("in word 0 not stored");
	status_reserved_a: assert property (ar_take && rd_hit[1]
		|=> s_axi_rdata[31:16] == 16'h0 && s_axi_rdata[7:5] == 3'h0) // [R13]
		else $error("status reserved bits not zero");

	// ---------------------------------------------------------------
	// strobe length and bus protocol checks
	// ---------------------------------------------------------------
	// [R3] helper: cycles the ready strobe has stood since its last set
	// a counter, since a 32-fold repetition would be unrolled by the tools
	logic [6:0] ready_run;
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ready_run <= 7'h00;
		end else if (strobe_set[READY_BIT] || !cmd_data_ready) begin
			ready_run <= 7'h00;
		end else begin
			ready_run <= ready_run + 7'h01;
		end
	end
	// [R3] full hold length
	ready_length_a: assert property ($fell(cmd_data_ready) // [R3]
		|-> ready_run == 7'(STROBE_HOLD_CYCLES))
		else $error("data ready strobe length wrong");
	// [R5] stall written as one
	sequence stall_written;
		wr_fire && wr_hit[0] && wr_strb[0] && wr_data[STALL_BIT];
	endsequence
	stall_seq_a: assert property (stall_written |=> cmd_stall ##1 cmd_stall) // [R5]
		else $error("stall strobe not raised for a written one");
	// [R9] write response held
	write_resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready // [R9]
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before acceptance");
	// [R7] read response held
	read_resp_hold_a: assert property (s_axi_rvalid && !s_axi_rready // [R7]
		|=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read response changed before acceptance");
	// [R13] unmapped write flagged
	unmapped_write_a: assert property (wr_fire && !wr_known // [R13]
		|=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
		else $error("unmapped write not flagged");
	// [R13] config upper bits
	config_reserved_a: assert property (sw_config_reg[31:8] == 24'h000000) // [R13]
		else $error("config reserved bit set");
	// [R12] last in-data word
	in_word3_a: assert property (wr_fire && wr_hit[7] && wr_strb == 4'hF // [R12]
		|=> ctrl_in_data[127:96] == $past(wr_data))
		else $error("in word 3 not stored");
	// [R13] one read pending
	read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready) // [R13]
		else $error("read address accepted while a response is pending");
	// [R13] one write pending
	write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) // [R13]
		else $error("write accepted while a response is pending");
endmodule : usb_device_control_endpoint_regs

// *** sim/usb_engine_model.sv ***
// far-side usb engine model: supplies link status and watches strobes
module usb_engine_model
	import usb_ctrl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire link_status_type link_set,
	input wire strobe_type strobes,
	input wire logic [127:0] ctrl_in_data,
	output logic [7:0] host_config_value,
	output logic [4:0] ctrl_rx_packet_size,
	output logic [7:0] last_len,
	output logic [127:0] sent_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] count;
	logic ready_seen;
	// status moves only on clock edges, as a synchronous engine would
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			host_config_value <= 8'h00;
			ctrl_rx_packet_size <= 5'h00;
			count <= 8'h00;
			last_len <= 8'h00;
			ready_seen <= 1'b0;
			sent_data <= '0;
		end else begin
			host_config_value <= link_set.host_config_value;
			ctrl_rx_packet_size <= link_set.ctrl_rx_packet_size;
			if (strobes != 4'h0) begin
				count <= count + 8'h01;
			end else if (count != 8'h00) begin
				last_len <= count;
				count <= 8'h00;
			end
			ready_seen <= strobes.data_ready;
			if (strobes.data_ready && !ready_seen) begin
				sent_data <= ctrl_in_data;
			end
		end
	end
endmodule : usb_engine_model

// *** sim/testbench.sv ***
// self-checking bench for the usb control register block
module testbench
	import usb_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] s_axi_awaddr = '0;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [31:0] s_axi_araddr = '0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	logic [7:0] host_config_value;
	logic [4:0] ctrl_rx_packet_size;
	logic fetch, last_pkt, stall, ready;
	logic [7:0] sw_config_value;
	logic [31:0] endpoint_a_identity, endpoint_a_control;
	logic [127:0] ctrl_in_data, sent_data;
	logic [7:0] last_len;
	link_status_type link_set = '0;
	strobe_type strobes;
	int compares = 0;
	int miscompares = 0;
	logic [31:0] regs [4] = '{SW_CONFIG_ADDR, EP_A_IDENTITY_ADDR, EP_A_CONTROL_ADDR,
		CTRL_STATUS_ADDR};
	logic [31:0] masks [4] = '{SW_CONFIG_MASK, EP_A_IDENTITY_MASK, EP_A_CONTROL_MASK, 32'h0};
	logic [31:0] pats [2] = '{32'hFFFFFFFF, 32'h89ABCDEF};
	logic [127:0] words;
	logic [31:0] status;
	assign strobes = {fetch, last_pkt, stall, ready};
	usb_device_control_endpoint_regs i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.host_config_value(host_config_value), .ctrl_rx_packet_size(ctrl_rx_packet_size),
		.setup_bulkout_fetch(fetch), .cmd_last_packet(last_pkt), .cmd_stall(stall),
		.cmd_data_ready(ready), .sw_config_value(sw_config_value),
		.endpoint_a_identity(endpoint_a_identity), .endpoint_a_control(endpoint_a_control),
		.ctrl_in_data(ctrl_in_data));
	usb_engine_model i_engine (.sys_clk(sys_clk), .rst_n(rst_n), .link_set(link_set),
		.strobes(strobes), .ctrl_in_data(ctrl_in_data), .host_config_value(host_config_value),
		.ctrl_rx_packet_size(ctrl_rx_packet_size), .last_len(last_len), .sent_data(sent_data));
	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic check(input logic [127:0] got, input logic [127:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : check
	task automatic axi_write(input logic [31:0] addr, input logic [31:0] data,
		input logic [1:0] resp);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge sys_clk);
		s_axi_awaddr <= addr;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= data;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (!s_axi_bvalid) @(posedge sys_clk);
		s_axi_bready <= 1'b0;
		check(s_axi_bresp, resp);
	endtask : axi_write
	task automatic axi_read(input logic [31:0] addr, input logic [31:0] exp, input logic [1:0] resp);
		@(posedge sys_clk);
		s_axi_araddr <= addr;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge sys_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge sys_clk);
		s_axi_rready <= 1'b0;
		check(s_axi_rresp, resp);
		check(s_axi_rdata, exp);
	endtask : axi_read
	task automatic close_out();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out
	// ---------------------------------------------------------------
	// clock, watchdog and tests
	// ---------------------------------------------------------------
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end
	// generous margin: the sequence needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		miscompares++;
		close_out();
	end
	initial begin
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		axi_read(CMD_STROBES_ADDR, RESET_VALUE, RESP_OKAY);
		for (int k = 0; k < 4; k++) axi_read(regs[k], RESET_VALUE, RESP_OKAY);
		for (int k = 0; k < CTRL_IN_WORDS; k++) begin
			axi_read(CTRL_IN_WORD0_ADDR + 4 * k, 32'h0, RESP_OKAY);
		end
		$display("test reset values done");
		link_set <= '{8'hA5, 5'h1B};
		status = 32'h0000A51B;
		for (int p = 0; p < 2; p++) begin
			for (int k = 0; k < 4; k++) begin
				axi_write(regs[k], pats[p], RESP_OKAY);
				axi_read(regs[k], (k == 3) ? status : pats[p] & masks[k], RESP_OKAY);
			end
		end
		check(sw_config_value, 8'hEF);
		check(endpoint_a_identity, 32'h01ABCDEF);
		check(endpoint_a_control, 32'h0000006F);
		$display("test register fields done");
		for (int i = 0; i < STROBE_COUNT; i++) begin
			axi_write(CMD_STROBES_ADDR, 32'h1 << i, RESP_OKAY);
			check(strobes, 4'h1 << i);
			axi_read(CMD_STROBES_ADDR, 32'h1 << i, RESP_OKAY);
			repeat (40) @(posedge sys_clk);
			check(last_len, STROBE_HOLD_CYCLES);
			check(strobes, 4'h0);
		end
		axi_write(CMD_STROBES_ADDR, 32'hFFFFFFF0, RESP_OKAY);
		check(strobes, 4'h0);
		axi_read(CMD_STROBES_ADDR, 32'h0, RESP_OKAY);
		$display("test strobes done");
		for (int k = 0; k < CTRL_IN_WORDS; k++) begin
			words[32 * k +: 32] = 32'h13579BD0 + k;
			axi_write(CTRL_IN_WORD0_ADDR + 4 * k, 32'h13579BD0 + k, RESP_OKAY);
		end
		axi_write(CMD_STROBES_ADDR, 32'h1, RESP_OKAY);
		repeat (3) @(posedge sys_clk);
		check(sent_data, words);
		check(ctrl_in_data, words);
		axi_write(32'hFFF06038, 32'hFFFFFFFF, RESP_SLVERR);
		axi_read(32'hFFF06038, 32'h0, RESP_SLVERR);
		axi_read(SW_CONFIG_ADDR, 32'h000000EF, RESP_OKAY);
		$display("test in data and unmapped done");
		close_out();
	end
endmodule : testbench
